// ---- hdl/cpuif_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpuif_map.svh"
// group 1 acknowledge and group enable registers of the cpu interface
module cpuif_regs
    import cpuif_pkg::*;
#(
    parameter int ID_BITS = `ID_WIDTH_FULL
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire sysreg_req_t req,
    input  wire sysreg_ctl_t ctl,
    input  wire pending_t    pending,
    input  wire logic        core_irq_masked,
    output var sysreg_rsp_t  rsp,
    output logic             ack_pulse,
    output logic [23:0]      ack_id,
    output logic             retarget_pulse,
    output logic [23:0]      retarget_id,
    output logic             group0_on,
    output logic             secure_group1_on,
    output logic             nonsecure_group1_on,
    output logic             virt_group0_on,
    output logic             virt_group1_on,
    output logic             virt_group0_wr,
    output logic             virt_group1_wr,
    output logic             ack_sync_hold
);
    // all block state in one record
    typedef struct packed {
        sysreg_rsp_t rsp;
        logic        ack;
        logic [23:0] ack_id;
        logic        retarget;
        logic [23:0] retarget_id;
        logic        g0_en;
        logic        g1s_en;
        logic        g1ns_en;
        logic        vg0;
        logic        vg1;
        logic        vg0_wr;
        logic        vg1_wr;
        logic        sync;
    } state_t;

    state_t  s_q;
    state_t  s_d;
    result_t route;
    logic    nsec;
    logic    id_wide;
    logic    g1_cur;
    logic    g1_new;
    logic    g1_fall_s;
    logic    g1_fall_ns;
    logic [23:0] id_mask;

    cpuif_route u_route (
        .req    (req),
        .ctl    (ctl),
        .result (route)
    );

    // identifier masking: a short implementation clears the upper byte
    always_comb begin
        id_wide = (ID_BITS > `ID_WIDTH_SHORT) && ctl.wide_identifier;
        id_mask = id_wide ? 24'hffffff : 24'h00ffff; // [R5]
        nsec    = ctl.nonsecure_state_bit | ~ctl.el3_present;
        g1_cur  = nsec ? s_q.g1ns_en : s_q.g1s_en;
        g1_new  = req.wdata[`ENABLE_BIT];
    end

    // next state
    always_comb begin
        s_d            = s_q;
        s_d.rsp.done   = 1'b0;
        s_d.ack        = 1'b0;
        s_d.retarget   = 1'b0;
        s_d.vg0_wr     = 1'b0;
        s_d.vg1_wr     = 1'b0;
        g1_fall_s      = 1'b0;
        g1_fall_ns     = 1'b0;
        if (req.valid) begin
            s_d.rsp.done   = 1'b1;
            s_d.rsp.result = route;
            s_d.rsp.rdata  = 32'h00000000; // [R2] [R24]
            // trapped or undefined accesses leave every register alone
            if (route == RES_DONE) begin // [R25]
                unique case (req.sel)
                    REG_GROUP1_ACK: begin
                        if (pending.valid && pending.group1 && pending.signallable &&
                            (pending.secure == ~nsec)) begin
                            s_d.rsp.rdata[23:0] = pending.id & id_mask; // [R1] [R3]
                            s_d.ack             = 1'b1; // [R1]
                            s_d.ack_id          = pending.id & id_mask;
                            // hold off re-signalling until the acknowledge is seen
                            s_d.sync            = core_irq_masked; // [R6]
                        end else if (pending.valid && pending.group1 && pending.signallable) begin
                            s_d.rsp.rdata[23:0] = pending.secure ? `ID_SPECIAL_SECURE
                                                                 : `ID_SPECIAL_NSEC; // [R4]
                        end else begin
                            s_d.rsp.rdata[23:0] = `ID_SPECIAL_NONE; // [R4]
                        end
                    end
                    REG_GROUP0_EN: begin
                        if (req.write) begin
                            s_d.g0_en = req.wdata[`ENABLE_BIT]; // [R12] [R24]
                            if (s_q.g0_en && !req.wdata[`ENABLE_BIT] && pending.valid &&
                                !pending.group1 && pending.one_of_n) begin
                                s_d.retarget    = 1'b1; // [R14]
                                s_d.retarget_id = pending.id;
                            end
                        end
                        s_d.rsp.rdata[`ENABLE_BIT] = req.write ? 1'b0 : s_q.g0_en; // [R12]
                    end
                    REG_GROUP1_EN: begin
                        if (req.write) begin
                            // one storage bit per bank doubles as the monitor alias
                            if (nsec) begin
                                s_d.g1ns_en = g1_new; // [R19] [R20]
                                g1_fall_ns  = s_q.g1ns_en && !g1_new;
                            end else begin
                                s_d.g1s_en = g1_new; // [R19] [R20]
                                g1_fall_s  = s_q.g1s_en && !g1_new;
                            end
                        end
                        s_d.rsp.rdata[`ENABLE_BIT] = req.write ? 1'b0 : g1_cur; // [R19]
                    end
                    REG_MON_G1_EN: begin
                        if (req.write) begin
                            s_d.g1s_en  = req.wdata[`MON_SECURE_BIT]; // [R23] [R20]
                            s_d.g1ns_en = req.wdata[`MON_NSEC_BIT]; // [R23] [R20]
                            g1_fall_s   = s_q.g1s_en && !req.wdata[`MON_SECURE_BIT];
                            g1_fall_ns  = s_q.g1ns_en && !req.wdata[`MON_NSEC_BIT];
                        end
                        s_d.rsp.rdata[`MON_SECURE_BIT] = req.write ? 1'b0 : s_q.g1s_en; // [R23]
                        s_d.rsp.rdata[`MON_NSEC_BIT]   = req.write ? 1'b0 : s_q.g1ns_en;
                    end
                endcase
                if (pending.valid && pending.group1 && pending.one_of_n &&
                    ((g1_fall_s && pending.secure) || (g1_fall_ns && !pending.secure))) begin
                    s_d.retarget    = 1'b1; // [R22]
                    s_d.retarget_id = pending.id;
                end
            end else if (route == RES_VIRTUAL) begin
                // virtual copies live in the hypervisor's control register image
                if (req.sel == REG_GROUP0_EN) begin
                    if (req.write) begin
                        s_d.vg0    = req.wdata[`ENABLE_BIT]; // [R13]
                        s_d.vg0_wr = 1'b1;
                    end
                    s_d.rsp.rdata[`ENABLE_BIT] = req.write ? 1'b0 : s_q.vg0;
                end else if (req.sel == REG_GROUP1_EN) begin
                    if (req.write) begin
                        s_d.vg1    = req.wdata[`ENABLE_BIT]; // [R21]
                        s_d.vg1_wr = 1'b1;
                    end
                    s_d.rsp.rdata[`ENABLE_BIT] = req.write ? 1'b0 : s_q.vg1;
                end
            end
        end
        // sync hold lasts one cycle, just long enough for the pending view to drop
        if (s_q.sync && !s_d.ack)
            s_d.sync = 1'b0;
    end

    // register the record; all enables start disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q         <= '0;
            s_q.g0_en   <= `ENABLE_RESET; // [R15]
            s_q.g1s_en  <= `ENABLE_RESET; // [R15]
            s_q.g1ns_en <= `ENABLE_RESET; // [R15]
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the record
    assign rsp                 = s_q.rsp;
    assign ack_pulse           = s_q.ack;
    assign ack_id              = s_q.ack_id;
    assign retarget_pulse      = s_q.retarget;
    assign retarget_id         = s_q.retarget_id;
    assign group0_on           = s_q.g0_en;
    assign secure_group1_on    = s_q.g1s_en;
    assign nonsecure_group1_on = s_q.g1ns_en;
    assign virt_group0_on      = s_q.vg0;
    assign virt_group1_on      = s_q.vg1;
    assign virt_group0_wr      = s_q.vg0_wr;
    assign virt_group1_wr      = s_q.vg1_wr;
    assign ack_sync_hold       = s_q.sync;
endmodule
`default_nettype wire

// ---- hdl/cpuif_route.sv ----
`timescale 1ns/1ps
`default_nettype none
// decides whether an access proceeds, goes virtual or traps
module cpuif_route
    import cpuif_pkg::*;
(
    input  wire sysreg_req_t req,
    input  wire sysreg_ctl_t ctl,
    output var result_t      result
);
    logic g1;
    logic route_hyp;
    logic route_mon;
    logic tall;
    logic nsec;

    always_comb begin
        g1        = (req.sel != REG_GROUP0_EN);
        route_hyp = g1 ? ctl.hyp_normal_irq_routing : ctl.hyp_fast_irq_routing;
        route_mon = g1 ? ctl.monitor_normal_int_route : ctl.monitor_fast_int_route;
        tall      = g1 ? ctl.trap_all_group1 : ctl.trap_all_group0;
        nsec      = ctl.nonsecure_state_bit | ~ctl.el3_present;
        result    = RES_DONE;
        if (req.level == 2'd0) begin
            result = RES_UNDEF; // [R8]
        end else if (req.sel == REG_MON_G1_EN) begin
            if (req.level != 2'd3 || !ctl.el3_present)
                result = RES_UNDEF;
            else if (!ctl.sysreg_if_on[2])
                result = RES_TRAP_L3; // [R9]
        end else if (req.sel == REG_GROUP1_ACK && req.write) begin
            result = RES_UNDEF; // [R8]
        end else if (!ctl.sysreg_if_on[req.level - 2'd1]) begin
            result = (req.level == 2'd1) ? RES_TRAP_L1 :
                     (req.level == 2'd2) ? RES_TRAP_L2 : RES_TRAP_L3; // [R9]
        end else if (req.level == 2'd1 && nsec && tall) begin
            result = RES_TRAP_L2; // [R10] [R17]
        end else if (ctl.el3_present && route_mon &&
                     (req.level == 2'd2 || (req.level == 2'd1 && (!nsec || !route_hyp)))) begin
            result = RES_TRAP_L3; // [R11] [R18]
        end else if (req.level == 2'd1 && nsec && route_hyp) begin
            result = RES_VIRTUAL; // [R7] [R16]
        end
    end
endmodule
`default_nettype wire

// ---- pkg/cpuif_map.svh ----
// Behaviour
// R1 - reading the group 1 acknowledge register returns the signalled identifier and acknowledges it
// R2 - acknowledge word is 32 bits: identifier in [23:0], [31:24] read zero
// R3 - identifier returned only if pending interrupt is signallable and acknowledgeable here
// R4 - unobservable highest pending interrupt returns special identifier 1020, 1021 or 1023
// R5 - identifier field is 16 or 24 bits; with 16, bits [23:16] read zero
// R6 - acknowledge reads are self-synchronising while the core masks interrupts
// R7 - non-secure EL1 reaches physical acknowledge only with irq routing 0, else virtual
// R8 - acknowledge register is read-only at EL1 to EL3, inaccessible at EL0
// R9 - a level whose system-register enable is 0 traps to itself
// R10 - trap-all-group-1 set makes non-secure EL1 acknowledge reads trap to EL2
// R11 - monitor irq route traps secure EL1, EL2 and unrouted non-secure EL1 reads to EL3
// R12 - group 0 enable bit [0] enables group 0; bits [31:1] read zero
// R13 - virtual group 0 enable accesses update the virtual group 0 enable bit
// R14 - group 0 enable falling with 1-of-N group 0 pending retargets it elsewhere
// R15 - every group enable bit resets to 0
// R16 - non-secure EL1 reaches physical group 0 enable only with fast routing 0
// R17 - trap-all-group-0 set makes non-secure EL1 group 0 enable accesses trap to EL2
// R18 - monitor fast route 1 traps secure EL1 and EL2 group 0 enable accesses to EL3
// R19 - group 1 enable is banked per security state; bit [0] enables the current state's group
// R20 - with EL3 present, banked group 1 enables alias the monitor group 1 enable bits
// R21 - virtual group 1 enable accesses update the virtual group 1 enable bit
// R22 - group 1 enable falling with 1-of-N group 1 pending retargets it elsewhere
// R23 - monitor group 1 enable: bit [1] secure, bit [0] non-secure, each resets 0
// R24 - writes to reserved enable bits are ignored; they read zero
// R25 - a trapped access changes no state and activates no interrupt
`ifndef CPUIF_MAP_SVH
`define CPUIF_MAP_SVH
`define ID_WIDTH_FULL      24
`define ID_WIDTH_SHORT     16
`define ID_SPECIAL_SECURE  24'h0003fc
`define ID_SPECIAL_NSEC    24'h0003fd
`define ID_SPECIAL_NONE    24'h0003ff
`define ENABLE_BIT         0
`define MON_SECURE_BIT     1
`define MON_NSEC_BIT       0
`define ENABLE_RESET       1'b0
`endif

// ---- pkg/cpuif_pkg.sv ----
package cpuif_pkg;
    // which register the core names in a system-register access
    typedef enum logic [1:0] {
        REG_GROUP1_ACK  = 2'b00,
        REG_GROUP0_EN   = 2'b01,
        REG_GROUP1_EN   = 2'b10,
        REG_MON_G1_EN   = 2'b11
    } reg_sel_t;

    // where an access ends up
    typedef enum logic [2:0] {
        RES_DONE    = 3'b000,
        RES_VIRTUAL = 3'b001,
        RES_TRAP_L1 = 3'b010,
        RES_TRAP_L2 = 3'b011,
        RES_TRAP_L3 = 3'b100,
        RES_UNDEF   = 3'b101
    } result_t;

    // system-register request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        reg_sel_t    sel;
        logic [1:0]  level;
        logic [31:0] wdata;
    } sysreg_req_t;

    // control bits held elsewhere in the core
    typedef struct packed {
        logic       el3_present;
        logic       nonsecure_state_bit;
        logic       monitor_fast_int_route;
        logic       monitor_normal_int_route;
        logic       hyp_fast_irq_routing;
        logic       hyp_normal_irq_routing;
        logic       trap_all_group0;
        logic       trap_all_group1;
        logic [2:0] sysreg_if_on;
        logic       wide_identifier;
    } sysreg_ctl_t;

    // highest priority pending interrupt as the distributor side offers it
    typedef struct packed {
        logic        valid;
        logic        group1;
        logic        secure;
        logic        one_of_n;
        logic        signallable;
        logic [23:0] id;
    } pending_t;

    // answer to the core
    typedef struct packed {
        logic        done;
        result_t     result;
        logic [31:0] rdata;
    } sysreg_rsp_t;
endpackage

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// processing element side: one system-register access at a time
module core_model
    import cpuif_pkg::*;
(
    input  wire logic        clk,
    input  wire sysreg_rsp_t rsp,
    output var sysreg_req_t  req
);
    sysreg_rsp_t got;
    initial req = '0;
    // request held over the taking edge, answer sampled once settled
    task automatic access(input logic w, input reg_sel_t s, input logic [1:0] l, input logic [31:0] d);
        int n;
        @(negedge clk);
        req <= '{1'b1, w, s, l, d};
        @(negedge clk);
        // released data inverted so a stale word never passes for a live one
        req <= '{1'b0, w, s, l, ~d};
        n = 0;
        while (rsp.done !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        got = rsp;
    endtask
endmodule
`default_nettype wire

// ---- testbench/cpuif_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// port-level checks on access outcomes, acknowledge and retarget pulses, and enable reset values
module cpuif_regs_props
    import cpuif_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire sysreg_req_t req,
    input wire sysreg_ctl_t ctl,
    input wire logic        core_irq_masked,
    input wire sysreg_rsp_t rsp,
    input wire logic        ack_pulse,
    input wire logic [23:0] ack_id,
    input wire logic        retarget_pulse,
    input wire logic        group0_on,
    input wire logic        secure_group1_on,
    input wire logic        nonsecure_group1_on,
    input wire logic        ack_sync_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // an access taken this edge, an acknowledge read, the non-secure state, and an el1 acknowledge read
    wire logic take   = req.valid && clk_en;
    wire logic ack_rd = take && !req.write && req.sel == REG_GROUP1_ACK;
    wire logic nsec   = !ctl.el3_present || ctl.nonsecure_state_bit;
    wire logic el1_rd = ack_rd && req.level == 2'd1;
    done_one_cycle_a: assert property (take |=> rsp.done)
        else $error("no answer one cycle after an access");
    ack_top_zero_a: assert property (rsp.done |-> rsp.rdata[31:24] == 8'h00)
        else $error("acknowledge top byte not zero");
    ack_from_read_a: assert property (ack_pulse |-> $past(ack_rd) && rsp.result == RES_DONE
        && rsp.rdata[23:0] == ack_id)
        else $error("acknowledge without a matching read");
    el0_refused_a: assert property (take && req.level == 2'd0 |=> rsp.result == RES_UNDEF)
        else $error("level 0 access not refused");
    sysreg_trap_a: assert property (el1_rd && !ctl.sysreg_if_on[0] |=> rsp.result == RES_TRAP_L1 && !ack_pulse)
        else $error("disabled interface did not trap to el1");
    group1_trap_a: assert property (el1_rd && ctl.sysreg_if_on[0] && nsec && ctl.trap_all_group1
        |=> rsp.result == RES_TRAP_L2 && !ack_pulse)
        else $error("trap all group 1 did not trap to el2");
    narrow_id_a: assert property (rsp.done && !$past(ctl.wide_identifier) |-> rsp.rdata[23:16] == 8'h00)
        else $error("narrow identifier upper bits set");
    enable_resv_a: assert property (rsp.done && $past(req.sel) != REG_GROUP1_ACK |-> rsp.rdata[31:2] == 30'h0)
        else $error("reserved enable bits not zero");
    sync_hold_a: assert property (ack_sync_hold |-> ack_pulse && $past(core_irq_masked))
        else $error("sync hold without masked acknowledge");
    retarget_write_a: assert property (retarget_pulse |-> $past(take && req.write) && rsp.done)
        else $error("retarget without an enable write");
    reset_off_a: assert property ($fell(rst) |-> !group0_on && !secure_group1_on && !nonsecure_group1_on)
        else $error("group enable set after reset");
    cover property (ack_pulse && ack_sync_hold);
    cover property (retarget_pulse);
    cover property (rsp.done && rsp.result == RES_VIRTUAL);
endmodule

bind cpuif_regs cpuif_regs_props chk_i (.clk, .rst, .clk_en, .req, .ctl, .core_irq_masked, .rsp,
    .ack_pulse, .ack_id, .retarget_pulse, .group0_on, .secure_group1_on, .nonsecure_group1_on,
    .ack_sync_hold);
`default_nettype wire

// ---- testbench/tb_cpu_if_group1_ack_and_group_enables.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpuif_map.svh"
// self-checking bench for the group 1 acknowledge and group enable registers
module tb_cpu_if_group1_ack_and_group_enables
    import cpuif_pkg::*;
;
    localparam sysreg_ctl_t BASE = '{el3_present: 1'b1, nonsecure_state_bit: 1'b1,
        sysreg_if_on: 3'b111, wide_identifier: 1'b1, default: '0};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        core_irq_masked = 1'b0;
    sysreg_ctl_t ctl = BASE;
    pending_t    pending = '0;
    sysreg_req_t req;
    sysreg_rsp_t rsp;
    logic [23:0] ack_id, retarget_id;
    logic        ack_pulse, retarget_pulse, group0_on, secure_group1_on, nonsecure_group1_on;
    logic        virt_group0_on, virt_group1_on, virt_group0_wr, virt_group1_wr, ack_sync_hold;
    int          failures = 0, samples_checked = 0, cycles = 0;

    cpuif_regs #(.ID_BITS(24)) DUT (.clk, .rst, .clk_en, .req, .ctl, .pending, .core_irq_masked, .rsp,
        .ack_pulse, .ack_id, .retarget_pulse, .retarget_id, .group0_on, .secure_group1_on,
        .nonsecure_group1_on, .virt_group0_on, .virt_group1_on, .virt_group0_wr, .virt_group1_wr,
        .ack_sync_hold);
    core_model core (.clk, .rsp, .req);

    always #12.5 clk = ~clk;
    // hang guard: about sixty cycles cover every scenario
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic pending_t pend(logic g1, logic sec, logic one, logic [23:0] id);
        return '{1'b1, g1, sec, one, 1'b1, id};
    endfunction

    task automatic t_reset;
        chk(32'({group0_on, secure_group1_on, nonsecure_group1_on}), 32'h0);
        // with the clock enable low the block must neither answer nor take a write
        clk_en = 1'b0;
        core.access(1'b1, REG_GROUP0_EN, 2'd1, 32'h1);
        chk(32'({core.got.done, group0_on}), 32'h0);
        clk_en = 1'b1;
        core.access(1'b0, REG_GROUP0_EN, 2'd1, 32'h0);
        chk(32'(core.got.done), 32'h1);
        chk(core.got.rdata, 32'h0);
    endtask
    task automatic t_ack;
        pending = pend(1'b1, 1'b0, 1'b0, 24'ha5c3e1);
        core_irq_masked = 1'b1;
        core.access(1'b0, REG_GROUP1_ACK, 2'd1, 32'h0);
        chk(core.got.rdata, 32'h00a5c3e1);
        chk(32'({ack_pulse, ack_sync_hold, ack_id}), 32'({2'b11, 24'ha5c3e1}));
        core_irq_masked = 1'b0;
        ctl.wide_identifier = 1'b0;
        core.access(1'b0, REG_GROUP1_ACK, 2'd1, 32'h0);
        chk(core.got.rdata, 32'h0000c3e1);
        pending.secure = 1'b1;
        core.access(1'b0, REG_GROUP1_ACK, 2'd1, 32'h0);
        chk(core.got.rdata, 32'(`ID_SPECIAL_SECURE));
        ctl.nonsecure_state_bit = 1'b0;
        pending.secure = 1'b0;
        core.access(1'b0, REG_GROUP1_ACK, 2'd1, 32'h0);
        chk(core.got.rdata, 32'(`ID_SPECIAL_NSEC));
        pending.valid = 1'b0;
        core.access(1'b0, REG_GROUP1_ACK, 2'd1, 32'h0);
        chk(core.got.rdata, 32'(`ID_SPECIAL_NONE));
    endtask
    // one refused or redirected acknowledge access per row; row 2 is a write
    task automatic t_route;
        result_t    exp [7] = '{RES_VIRTUAL, RES_UNDEF, RES_UNDEF, RES_TRAP_L1, RES_TRAP_L2,
                                RES_TRAP_L3, RES_TRAP_L3};
        logic [1:0] lvl [7] = '{2'd1, 2'd0, 2'd1, 2'd1, 2'd1, 2'd2, 2'd1};
        pending = pend(1'b1, 1'b0, 1'b0, 24'h000055);
        for (int i = 0; i < 7; i++) begin
            ctl = BASE;
            case (i)
                0: ctl.hyp_normal_irq_routing = 1'b1;
                3: ctl.sysreg_if_on = 3'b110;
                4: ctl.trap_all_group1 = 1'b1;
                5, 6: ctl.monitor_normal_int_route = 1'b1;
                default: ;
            endcase
            core.access(i == 2, REG_GROUP1_ACK, lvl[i], 32'h0);
            chk(32'({core.got.result, ack_pulse}), 32'({exp[i], 1'b0}));
        end
    endtask
    task automatic t_g0;
        ctl = BASE;
        pending = '0;
        core.access(1'b1, REG_GROUP0_EN, 2'd1, 32'hffffffff);
        core.access(1'b0, REG_GROUP0_EN, 2'd1, 32'h0);
        chk(core.got.rdata, 32'h1);
        chk(32'(group0_on), 32'h1);
        ctl.hyp_fast_irq_routing = 1'b1;
        core.access(1'b1, REG_GROUP0_EN, 2'd1, 32'h1);
        chk(32'({core.got.result, virt_group0_wr, virt_group0_on, group0_on}),
            32'({RES_VIRTUAL, 3'b111}));
        ctl = BASE;
        ctl.trap_all_group0 = 1'b1;
        core.access(1'b1, REG_GROUP0_EN, 2'd1, 32'h0);
        chk(32'({core.got.result, group0_on}), 32'({RES_TRAP_L2, 1'b1}));
        ctl = BASE;
        ctl.monitor_fast_int_route = 1'b1;
        core.access(1'b1, REG_GROUP0_EN, 2'd2, 32'h0);
        chk(32'({core.got.result, group0_on}), 32'({RES_TRAP_L3, 1'b1}));
        ctl = BASE;
        pending = pend(1'b0, 1'b0, 1'b1, 24'h00002a);
        core.access(1'b1, REG_GROUP0_EN, 2'd1, 32'h0);
        chk(32'({retarget_pulse, group0_on, retarget_id}), 32'({2'b10, 24'h00002a}));
    endtask
    task automatic t_g1;
        ctl = BASE;
        pending = '0;
        core.access(1'b1, REG_GROUP1_EN, 2'd1, 32'hffffffff);
        chk(32'({nonsecure_group1_on, secure_group1_on}), 32'h2);
        ctl.nonsecure_state_bit = 1'b0;
        core.access(1'b1, REG_GROUP1_EN, 2'd3, 32'h1);
        core.access(1'b0, REG_MON_G1_EN, 2'd3, 32'h0);
        chk(core.got.rdata, 32'h3);
        ctl = BASE;
        ctl.hyp_normal_irq_routing = 1'b1;
        core.access(1'b1, REG_GROUP1_EN, 2'd1, 32'h1);
        chk(32'({core.got.result, virt_group1_wr, virt_group1_on}), 32'({RES_VIRTUAL, 2'b11}));
        ctl = BASE;
        pending = pend(1'b1, 1'b0, 1'b1, 24'h000777);
        core.access(1'b1, REG_MON_G1_EN, 2'd3, 32'h2);
        chk(32'({retarget_pulse, nonsecure_group1_on, secure_group1_on, retarget_id}),
            32'({3'b101, 24'h000777}));
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_ack();
        t_route();
        t_g0();
        t_g1();
        tally_and_finish();
    end
endmodule
`default_nettype wire
